// ---- test/batch_handoff_handshake_port_tb_top.sv ----
`timescale 1ns/1ps
module batch_handoff_handshake_port_tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic send_req = 1'b0;
  logic [3:0] send_code = 4'h0;
  logic send_single = 1'b0;
  logic load_ok = 1'b0;
  logic send_busy, send_done, rx_single, rx_strobe, rx_busy;
  logic [3:0] rx_code;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_strobe = 0;
  bhhp_if link ();
  bhhp_discharge i_bhhp_discharge (.core_clk(core_clk), .nrst(nrst), .link(link.upstream),
    .send_req(send_req), .send_code(send_code), .send_single(send_single),
    .send_busy(send_busy), .send_done(send_done));
  bhhp_loading i_bhhp_loading (.core_clk(core_clk), .nrst(nrst), .link(link.downstream),
    .load_ok(load_ok), .rx_code(rx_code), .rx_single(rx_single), .rx_strobe(rx_strobe),
    .rx_busy(rx_busy));
  bhhp_assertions u_chk (.core_clk(core_clk), .nrst(nrst), .formula_code(link.formula_code),
    .single_cake(link.single_cake), .data_valid(link.data_valid),
    .batch_ready(link.batch_ready), .load_desired(link.load_desired),
    .data_taken(link.data_taken));
  // Clock and strobe counter
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) if (rx_strobe === 1'b1) n_strobe++;
  function automatic logic [4:0] expect_rx(input logic [3:0] c, input logic s);
    return {c, s};
  endfunction
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One batch; optional extra request while busy and loading held off
  task automatic xfer(input logic [3:0] c, input logic s, input bit dup, input int hold);
    int k;
    int n0;
    n0 = n_strobe;
    @(posedge core_clk);
    load_ok <= (hold == 0);
    send_req <= 1'b1;
    send_code <= c;
    send_single <= s;
    @(posedge core_clk);
    send_req <= 1'b0;
    send_code <= ~c;
    #1 check(8'h1, 8'(send_busy));
    if (dup) begin
      @(posedge core_clk);
      send_req <= 1'b1;
      @(posedge core_clk);
      send_req <= 1'b0;
    end
    if (hold > 0) begin
      repeat (hold + 20) @(posedge core_clk);
      check(8'h0, 8'({link.load_desired, rx_busy}));
      load_ok <= 1'b1;
    end
    k = 0;
    while (send_done !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    check(8'h1, 8'(k < 400));
    check(8'(expect_rx(c, s)), {3'h0, rx_code, rx_single});
    check(8'(n0 + 1), 8'(n_strobe));
    check(8'h0, 8'({link.formula_code, link.data_valid, link.batch_ready}));
    $display("transfer %h done", c);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
  // Corner codes, then random batches
  initial begin
    void'($urandom(94502));
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    xfer(4'hF, 1'b1, 1'b0, 0);
    xfer(4'h0, 1'b0, 1'b0, 0);
    xfer(4'h8, 1'b0, 1'b1, 0);
    xfer(4'h1, 1'b1, 1'b0, 30);
    for (int i = 0; i < 8; i++) begin
      xfer(4'($urandom_range(15)), 1'($urandom_range(1)), 1'($urandom_range(1)),
        int'($urandom_range(20)));
    end
    tally_and_finish();
  end
endmodule

// ---- test/bhhp_assertions.sv ----
`timescale 1ns/1ps
module bhhp_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [bhhp_pkg::FORMULA_W-1:0] formula_code,
  input wire logic single_cake,
  input wire logic data_valid,
  input wire logic batch_ready,
  input wire logic load_desired,
  input wire logic data_taken
);
  // One clock domain, quiet during reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_idle_zero;
    !batch_ready |-> formula_code == 4'h0 && !single_cake && !data_valid;
  endproperty
  property p_code_hold;
    data_valid && $past(data_valid) |-> $stable({formula_code, single_cake});
  endproperty
  property p_code_first;
    $rose(data_valid) |-> $stable(formula_code);
  endproperty
  property p_desire_first;
    $rose(data_valid) |-> load_desired;
  endproperty
  property p_taken_valid;
    $rose(data_taken) |-> data_valid && !load_desired;
  endproperty
  property p_desire_ready;
    $rose(load_desired) |-> batch_ready;
  endproperty
  property p_release;
    $rose(data_taken) |-> ##[1:40] !batch_ready;
  endproperty
  property p_taken_drop;
    $fell(batch_ready) |-> ##[1:40] !data_taken;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("code active while idle");
  a_code_hold: assert property (p_code_hold) else $error("code moved while valid");
  a_code_first: assert property (p_code_first) else $error("code not set first");
  a_desire_first: assert property (p_desire_first) else $error("valid before desire");
  a_taken_valid: assert property (p_taken_valid) else $error("taken without valid");
  a_desire_ready: assert property (p_desire_ready) else $error("desire without ready");
  a_release: assert property (p_release) else $error("ready not released");
  a_taken_drop: assert property (p_taken_drop) else $error("taken not released");
  // Main scenarios
  c_valid: cover property ($rose(data_valid));
  c_max: cover property (data_valid && formula_code == 4'hF);
  c_done: cover property ($fell(data_taken));
endmodule

// ---- verilog/bhhp_discharge.sv ----
`timescale 1ns/1ps
// Discharge end: sends batches to the downstream machine
module bhhp_discharge #(
  parameter int FILT = bhhp_pkg::FILT_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  bhhp_if.upstream link,
  input wire logic send_req,
  input wire logic [bhhp_pkg::FORMULA_W-1:0] send_code,
  input wire logic send_single,
  output logic send_busy,
  output logic send_done
);
  typedef enum logic [2:0] {BHHP_IDLE, BHHP_WLOAD, BHHP_SETUP, BHHP_VALID, BHHP_WREL}
    bhhp_dstate_e;
  bhhp_dstate_e st_reg;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] f_reg;
  logic [1:0] last_reg;
  logic [7:0] cnt_reg [2];
  logic [bhhp_pkg::FORMULA_W-1:0] code_reg;
  logic single_reg;

  initial begin
    if (FILT < 1 || FILT > 255) $error("FILT out of range");
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
    end else begin
      s1_reg <= {link.data_taken, link.load_desired};
      s2_reg <= s1_reg;
    end
  end
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        last_reg[i] <= 1'b0;
        cnt_reg[i] <= 8'h00;
        f_reg[i] <= 1'b0;
      end else begin
        last_reg[i] <= s2_reg[i];
        if (s2_reg[i] != last_reg[i]) begin
          cnt_reg[i] <= 8'h00;
        end else if (cnt_reg[i] < 8'(FILT)) begin
          cnt_reg[i] <= cnt_reg[i] + 8'h01;
        end else begin
          f_reg[i] <= s2_reg[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= BHHP_IDLE;
      code_reg <= bhhp_pkg::CODE_RST;
      single_reg <= bhhp_pkg::SIG_RST;
      send_done <= 1'b0;
    end else begin
      send_done <= 1'b0;
      case (st_reg)
        BHHP_IDLE: begin
          if (send_req) begin
            code_reg <= send_code;
            single_reg <= send_single;
            st_reg <= BHHP_WLOAD;
          end
        end
        BHHP_WLOAD: begin
          if (f_reg[0]) begin
            st_reg <= BHHP_SETUP;
          end
        end
        BHHP_SETUP: begin
          st_reg <= BHHP_VALID;
        end
        BHHP_VALID: begin
          if (f_reg[1]) begin
            st_reg <= BHHP_WREL;
          end
        end
        BHHP_WREL: begin
          if (!f_reg[1] && !f_reg[0]) begin
            st_reg <= BHHP_IDLE;
            send_done <= 1'b1;
          end
        end
        default: begin
          st_reg <= BHHP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    link.formula_code = (st_reg == BHHP_SETUP || st_reg == BHHP_VALID) ? code_reg
      : bhhp_pkg::CODE_RST;
    link.single_cake = (st_reg == BHHP_SETUP || st_reg == BHHP_VALID) ? single_reg : 1'b0;
  end
  assign link.data_valid = (st_reg == BHHP_VALID);
  // status toward partner
  // Ready drops in the release wait so the loading end can leave its taken state
  assign link.batch_ready = (st_reg == BHHP_WLOAD || st_reg == BHHP_SETUP
    || st_reg == BHHP_VALID);
  assign send_busy = (st_reg != BHHP_IDLE);
endmodule

// ---- verilog/bhhp_if.sv ----
`timescale 1ns/1ps
// Link between an upstream discharge end and a downstream loading end
interface bhhp_if;
  // plain level signals
  // Upstream to downstream
  logic [bhhp_pkg::FORMULA_W-1:0] formula_code;
  logic single_cake;
  logic data_valid;
  logic batch_ready;
  // Downstream to upstream
  logic load_desired;
  logic data_taken;
  modport upstream(
    output formula_code,
    output single_cake,
    output data_valid,
    output batch_ready,
    input load_desired,
    input data_taken
  );
  modport downstream(
    input formula_code,
    input single_cake,
    input data_valid,
    input batch_ready,
    output load_desired,
    output data_taken
  );
endinterface

// ---- verilog/bhhp_loading.sv ----
`timescale 1ns/1ps
// Operation
// - One fixed purpose per on/off circuit
// - Batch code is binary, MSB first
// - Same bit order at both ends
// - All code bits settled before sampling
// - Read data only while valid asserted
// - Sender provides dedicated data-valid signal
// - Batch data flows downstream only
// - Operational signals in both directions
// - Assert few signals, await partner response
// - Operational signals follow agreed order
// - Operational and single items are levels
// - Formula code is four bits, 0-15
// - Separate loading and discharge interfaces
module bhhp_loading #(
  parameter int FILT = bhhp_pkg::FILT_CYCLES,
  parameter int W = bhhp_pkg::FORMULA_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  bhhp_if.downstream link,
  input wire logic load_ok,
  output logic [bhhp_pkg::FORMULA_W-1:0] rx_code,
  output logic rx_single,
  output logic rx_strobe,
  output logic rx_busy
);
  localparam int NIN = W + 3;
  typedef enum logic [1:0] {BHHL_IDLE, BHHL_WAIT, BHHL_TAKEN} bhhl_state_e;
  bhhl_state_e st_reg;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] last_reg;
  logic [NIN-1:0] f_reg;
  logic [7:0] cnt_reg [NIN];

  initial begin
    if (W != 4) $error("Formula code must be four bits");
    if (FILT < 1 || FILT > 255) $error("FILT out of range");
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {link.batch_ready, link.data_valid, link.single_cake, link.formula_code};
      s2_reg <= s1_reg;
    end
  end
  for (genvar i = 0; i < NIN; i++) begin : g_filt
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        last_reg[i] <= 1'b0;
        cnt_reg[i] <= 8'h00;
        f_reg[i] <= 1'b0;
      end else begin
        last_reg[i] <= s2_reg[i];
        if (s2_reg[i] != last_reg[i]) begin
          cnt_reg[i] <= 8'h00;
        end else if (cnt_reg[i] < 8'(FILT)) begin
          cnt_reg[i] <= cnt_reg[i] + 8'h01;
        end else begin
          f_reg[i] <= s2_reg[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= BHHL_IDLE;
      rx_code <= bhhp_pkg::CODE_RST;
      rx_single <= bhhp_pkg::SIG_RST;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      case (st_reg)
        BHHL_IDLE: begin
          if (load_ok && f_reg[W+2]) begin
            st_reg <= BHHL_WAIT;
          end
        end
        BHHL_WAIT: begin
          if (f_reg[W+1]) begin
            rx_code <= f_reg[W-1:0];
            rx_single <= f_reg[W];
            rx_strobe <= 1'b1;
            st_reg <= BHHL_TAKEN;
          end
        end
        BHHL_TAKEN: begin
          if (!f_reg[W+1] && !f_reg[W+2]) begin
            st_reg <= BHHL_IDLE;
          end
        end
        default: begin
          st_reg <= BHHL_IDLE;
        end
      endcase
    end
  end

  assign link.load_desired = (st_reg == BHHL_WAIT);
  assign link.data_taken = (st_reg == BHHL_TAKEN);
  assign rx_busy = (st_reg != BHHL_IDLE);
endmodule

// ---- verilog/bhhp_pkg.sv ----
package bhhp_pkg;
  // Batch code widths
  localparam int FORMULA_W = 4;
  localparam int CODE_MAX = 15;
  // Stable-level filter length in clock cycles
  localparam int FILT_CYCLES = 3;
  // Reset values of the code and single-cake levels (rx_code, rx_single and their send-side registers)
  localparam logic SIG_RST = 1'b0;
  localparam logic [FORMULA_W-1:0] CODE_RST = 4'h0;
endpackage
